// ### rtl/cms_counter.sv
/*
 * One counter of a multi-counter timing controller: mode decode, arming,
 * terminal-count sequencing, load/hold reloads and gate capture.
 * Assumes a classic Wishbone master and source/gate synchronous to clk_i.
 */
`timescale 1ns/10ps
// Function
// - mode letter comes from the gate-control field and low mode field
// - letters M, P, T, U, W are reserved; host must avoid them
// - repetition bit clear disarms at terminal count; set keeps counting
// - only modes N, O, Q, R retrigger from the gate edge
// - only rising source and gate edges act
// - terminal-count state always counts next source edge; stops wait for it
// - mode A ignores gate and counts only after an arm command
// - mode A reloads from Load and disarms at every terminal count
// - listed modes reload from Load with gate low, Hold with gate high
// - listed modes capture count to Hold on gate edge then reload Load
// - capture mode copies count to Hold on gate edge, counting continues
module cms_counter
    import cms_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [7:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    output logic [31:0] dat_o,
    output logic ack_o,
    input wire logic source_i,
    input wire logic gate_i,
    output logic terminal_count_o,
    output logic armed_o,
    output logic irq_o
);
    logic [15:0] mode_reg, mode_next;
    logic [15:0] load_reg, load_next;
    logic [15:0] hold_reg, hold_next;
    logic [15:0] count_reg, count_next;
    logic armed_reg, armed_next;
    logic tc_reg, tc_next;
    logic [CMS_IRQ_W-1:0] ista_reg, ista_next;
    logic [CMS_IRQ_W-1:0] imask_reg, imask_next;
    logic [31:0] rdat_reg, rdat_next;
    logic ack_reg, ack_next;
    logic src_rise, gate_rise, gate_lvl;
    logic [2:0] gate_field;
    logic [2:0] low_field;
    logic repetition_bit;
    cms_mode_t mode;
    logic retrig_mode, capture_mode, gate_sel_mode, cap_reload_mode;
    logic wr, rd, cmd_wr;
    logic [CMS_IRQ_W-1:0] ev;
    logic count_en;

    cms_edge_det u_src (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .sig_i(source_i),
        .rise_o(src_rise),
        .level_o()
    );

    cms_edge_det u_gate (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .sig_i(gate_i),
        .rise_o(gate_rise),
        .level_o(gate_lvl)
    );

    // mode decode from the two fields
    assign gate_field = mode_reg[CMS_GATE_LSB +: 3];
    assign low_field = mode_reg[CMS_LOW_LSB +: 3];
    assign repetition_bit = mode_reg[CMS_REP_BIT];

    always_comb
    begin
        mode = CMS_MODE_A;
        // gate class: none, level (gate field 1..5), edge (6,7)
        case (gate_field == CMS_GATE_NONE ? 2'd0 : (gate_field[2:1] == 2'b11 ? 2'd2 : 2'd1))
            2'd0: mode = cms_mode_t'({low_field[2:0], 2'b00} - {2'b00, low_field[2:0]});
            2'd1: mode = cms_mode_t'({low_field[2:0], 2'b00} - {2'b00, low_field[2:0]} + 5'd1);
            2'd2: mode = cms_mode_t'({low_field[2:0], 2'b00} - {2'b00, low_field[2:0]} + 5'd2);
            default: mode = CMS_MODE_A;
        endcase
    end

    // option groups; reserved letters fall into no group
    assign retrig_mode = (mode == CMS_MODE_N) || (mode == CMS_MODE_O) ||
                         (mode == CMS_MODE_Q) || (mode == CMS_MODE_R);
    assign gate_sel_mode = (mode == CMS_MODE_S) || (mode == CMS_MODE_V);
    assign cap_reload_mode = retrig_mode;
    assign capture_mode = (mode == CMS_MODE_X);

    // counting is allowed when armed and gate rules permit, always in terminal count
    always_comb
    begin
        count_en = 1'b0;
        if (src_rise)
        begin
            if (tc_reg)
            begin
                count_en = 1'b1;
            end
            else if (armed_reg)
            begin
                // mode A and other gate-none modes ignore the gate
                if (gate_field == CMS_GATE_NONE || gate_sel_mode)
                begin
                    count_en = 1'b1;
                end
                else
                begin
                    count_en = gate_lvl;
                end
            end
        end
    end

    // bus decode: reads are taken on the first edge, writes land on the edge that samples ack high
    assign wr = cyc_i & stb_i & we_i & ack_reg;
    assign rd = cyc_i & stb_i & ~we_i & ~ack_reg;
    assign cmd_wr = wr && adr_i == CMS_OFF_CMD && sel_i[0];

    // counter, armed flag, hold and terminal-count sequencing
    always_comb
    begin
        count_next = count_reg;
        hold_next = hold_reg;
        armed_next = armed_reg;
        tc_next = tc_reg;
        ev = '0;
        if (count_en)
        begin
            if (tc_reg)
            begin
                // leaving terminal count: apply reload and due disarm now
                tc_next = 1'b0;
                if (gate_sel_mode && gate_lvl)
                begin
                    count_next = hold_reg;
                end
                else
                begin
                    count_next = load_reg;
                end
                if (!repetition_bit)
                begin
                    armed_next = 1'b0;
                    ev[CMS_IRQ_DISARM] = 1'b1;
                end
            end
            else if (count_reg == CMS_CNT_ONE)
            begin
                count_next = count_reg - CMS_CNT_ONE;
                tc_next = 1'b1;
                ev[CMS_IRQ_TC] = 1'b1;
            end
            else
            begin
                count_next = count_reg - CMS_CNT_ONE;
            end
        end
        if (gate_rise && armed_reg && (cap_reload_mode || capture_mode))
        begin
            hold_next = count_reg;
            ev[CMS_IRQ_GATE] = 1'b1;
            if (cap_reload_mode)
            begin
                count_next = load_reg;
                tc_next = 1'b0;
            end
        end
        if (cmd_wr && dat_i[CMS_CMD_LOAD])
        begin
            count_next = load_reg;
            tc_next = 1'b0;
        end
        if (cmd_wr && dat_i[CMS_CMD_DISARM])
        begin
            armed_next = 1'b0;
        end
        if (cmd_wr && dat_i[CMS_CMD_ARM])
        begin
            armed_next = 1'b1;
        end
        if (wr && adr_i == CMS_OFF_HOLD)
        begin
            hold_next = dat_i[15:0];
        end
    end

    // software-written registers and interrupt status
    always_comb
    begin
        mode_next = mode_reg;
        load_next = load_reg;
        imask_next = imask_reg;
        ista_next = ista_reg;
        if (wr && adr_i == CMS_OFF_MODE)
        begin
            mode_next = dat_i[15:0];
        end
        if (wr && adr_i == CMS_OFF_LOAD)
        begin
            load_next = dat_i[15:0];
        end
        if (wr && adr_i == CMS_OFF_IRQ_MASK)
        begin
            imask_next = dat_i[CMS_IRQ_W-1:0];
        end
        if (wr && adr_i == CMS_OFF_IRQ_STAT)
        begin
            ista_next = ista_reg & ~dat_i[CMS_IRQ_W-1:0];
        end
        ista_next = ista_next | ev; // set wins over clear
    end

    // read mux and single-cycle ack
    always_comb
    begin
        ack_next = cyc_i & stb_i & ~ack_reg;
        rdat_next = rdat_reg;
        if (rd)
        begin
            case (adr_i)
                CMS_OFF_MODE: rdat_next = {16'h0000, mode_reg};
                CMS_OFF_LOAD: rdat_next = {16'h0000, load_reg};
                CMS_OFF_HOLD: rdat_next = {16'h0000, hold_reg};
                CMS_OFF_COUNT: rdat_next = {16'h0000, count_reg};
                CMS_OFF_STAT: rdat_next = {30'h00000000, tc_reg, armed_reg};
                CMS_OFF_IRQ_STAT: rdat_next = {29'h0, ista_reg};
                CMS_OFF_IRQ_MASK: rdat_next = {29'h0, imask_reg};
                default: rdat_next = 32'h00000000;
            endcase
        end
    end

    // state registers
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            mode_reg <= CMS_MODE_RST;
            load_reg <= CMS_LOAD_RST;
            hold_reg <= CMS_HOLD_RST;
            count_reg <= CMS_COUNT_RST;
            armed_reg <= 1'b0;
            tc_reg <= 1'b0;
            ista_reg <= CMS_IRQ_RST;
            imask_reg <= CMS_IRQ_RST;
            rdat_reg <= 32'h00000000;
            ack_reg <= 1'b0;
        end
        else
        begin
            mode_reg <= mode_next;
            load_reg <= load_next;
            hold_reg <= hold_next;
            count_reg <= count_next;
            armed_reg <= armed_next;
            tc_reg <= tc_next;
            ista_reg <= ista_next;
            imask_reg <= imask_next;
            rdat_reg <= rdat_next;
            ack_reg <= ack_next;
        end
    end

    assign dat_o = rdat_reg;
    assign ack_o = ack_reg;
    assign terminal_count_o = tc_reg;
    assign armed_o = armed_reg;
    assign irq_o = |(ista_reg & imask_reg);

    // assertions
    a_tc_always_counts: assert property (@(posedge clk_i) disable iff (rst_i)
        tc_reg && src_rise |=> !tc_reg)
        else $error("terminal count not left on source edge");
    a_no_count_disarmed: assert property (@(posedge clk_i) disable iff (rst_i)
        !armed_reg && !tc_reg && !cmd_wr && !gate_rise |=> $stable(count_reg))
        else $error("count moved while disarmed");
    a_oneshot_disarm: assert property (@(posedge clk_i) disable iff (rst_i)
        tc_reg && src_rise && !repetition_bit && !cmd_wr |=> !armed_reg)
        else $error("no disarm after terminal count");
    a_repeat_keeps_armed: assert property (@(posedge clk_i) disable iff (rst_i)
        armed_reg && tc_reg && src_rise && repetition_bit && !cmd_wr |=> armed_reg)
        else $error("repetitive mode disarmed");
    a_mode_a_reload: assert property (@(posedge clk_i) disable iff (rst_i)
        mode == CMS_MODE_A && tc_reg && src_rise && !cmd_wr && !wr |=> count_reg == $past(load_reg))
        else $error("mode a did not reload from load");
    a_fall_no_count: assert property (@(posedge clk_i) disable iff (rst_i)
        !src_rise && !gate_rise && !cmd_wr |=> $stable(count_reg))
        else $error("count moved without rising edge");
    a_gate_sel_hold: assert property (@(posedge clk_i) disable iff (rst_i)
        gate_sel_mode && tc_reg && src_rise && gate_lvl && !cmd_wr |=> count_reg == $past(hold_reg))
        else $error("hold not used with gate high");
    a_capture_hold: assert property (@(posedge clk_i) disable iff (rst_i)
        capture_mode && armed_reg && gate_rise && !wr |=> hold_reg == $past(count_reg))
        else $error("count not captured to hold");
    a_retrig_reload: assert property (@(posedge clk_i) disable iff (rst_i)
        cap_reload_mode && armed_reg && gate_rise && !cmd_wr |=> count_reg == $past(load_reg))
        else $error("retrigger did not reload");
    a_arm_sets: assert property (@(posedge clk_i) disable iff (rst_i)
        cmd_wr && dat_i[CMS_CMD_ARM] |=> armed_reg)
        else $error("arm command not taken");
endmodule

// ### rtl/cms_edge_det.sv
/*
 * Active-going edge detector for the source and gate inputs.
 * Assumes inputs already synchronous to clk_i and active high.
 */
`timescale 1ns/10ps
module cms_edge_det
    import cms_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic sig_i,
    output logic rise_o,
    output logic level_o
);
    logic prev_reg;
    logic prev_next;

    // next value of the delayed copy
    always_comb
    begin
        prev_next = sig_i;
    end

    // register the delayed copy
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            prev_reg <= 1'b0;
        end
        else
        begin
            prev_reg <= prev_next;
        end
    end

    // only low-to-high transitions count, falling edges are dropped
    assign rise_o = sig_i & ~prev_reg;
    assign level_o = sig_i;
endmodule

// ### rtl/cms_pkg.sv
/*
 * Package for the counter mode-select and strobe block.
 * Holds register offsets, field positions, reset values and the mode letters.
 * Assumes a 32-bit classic Wishbone slave with word-aligned registers.
 */
package cms_pkg;
    // register byte offsets
    localparam logic [7:0] CMS_OFF_MODE = 8'h00;
    localparam logic [7:0] CMS_OFF_LOAD = 8'h04;
    localparam logic [7:0] CMS_OFF_HOLD = 8'h08;
    localparam logic [7:0] CMS_OFF_COUNT = 8'h0c;
    localparam logic [7:0] CMS_OFF_CMD = 8'h10;
    localparam logic [7:0] CMS_OFF_STAT = 8'h14;
    localparam logic [7:0] CMS_OFF_IRQ_STAT = 8'h18;
    localparam logic [7:0] CMS_OFF_IRQ_MASK = 8'h1c;
    // mode register field positions
    localparam int CMS_GATE_LSB = 13;
    localparam int CMS_LOW_LSB = 5;
    localparam int CMS_REP_BIT = 5;
    // command register bits
    localparam int CMS_CMD_ARM = 0;
    localparam int CMS_CMD_DISARM = 1;
    localparam int CMS_CMD_LOAD = 2;
    // interrupt status bits
    localparam int CMS_IRQ_TC = 0;
    localparam int CMS_IRQ_DISARM = 1;
    localparam int CMS_IRQ_GATE = 2;
    localparam int CMS_IRQ_W = 3;
    // reset values and the unit count step
    localparam logic [15:0] CMS_MODE_RST = 16'h0000;
    localparam logic [15:0] CMS_LOAD_RST = 16'h0000;
    localparam logic [15:0] CMS_HOLD_RST = 16'h0000;
    localparam logic [15:0] CMS_COUNT_RST = 16'h0000;
    localparam logic [15:0] CMS_CNT_ONE = 16'h0001;
    localparam logic [2:0] CMS_IRQ_RST = 3'h0;
    // gate-control encodings of interest
    localparam logic [2:0] CMS_GATE_NONE = 3'h0;
    // mode letters, index = three times the low field plus gate class
    typedef enum logic [4:0] {
        CMS_MODE_A, CMS_MODE_B, CMS_MODE_C, CMS_MODE_D, CMS_MODE_E, CMS_MODE_F,
        CMS_MODE_G, CMS_MODE_H, CMS_MODE_I, CMS_MODE_J, CMS_MODE_K, CMS_MODE_L,
        CMS_MODE_M, CMS_MODE_N, CMS_MODE_O, CMS_MODE_P, CMS_MODE_Q, CMS_MODE_R,
        CMS_MODE_S, CMS_MODE_T, CMS_MODE_U, CMS_MODE_V, CMS_MODE_W, CMS_MODE_X
    } cms_mode_t;
endpackage

// ### sim/cms_counter_tb.sv
/*
 * Self-checking bench for the counter mode-select block: bus tasks, mode runs, interrupts.
 * Assumes the far-side model cms_src_gate and the one-wait-state Wishbone slave.
 */
`timescale 1ns/10ps
module cms_counter_tb
    import cms_pkg::*;
();
    typedef struct { string nm; logic [31:0] v; } cms_exp_t;
    logic clk_i, rst_i, cyc, stb, we;
    logic [7:0] adr;
    logic [3:0] sel;
    logic [31:0] dat;
    cms_exp_t e_front;
    logic [31:0] dat_o;
    logic ack_o, source, gate, tc, armed, irq;
    int fails = 0, n_checks = 0;
    int seed = 32'h316c48be;
    cms_exp_t exp_q[$];
    // clock and design
    always #5 clk_i = ~clk_i;
    cms_counter i_cms_counter (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr),
        .sel_i(sel), .dat_i(dat), .dat_o(dat_o), .ack_o(ack_o), .source_i(source), .gate_i(gate),
        .terminal_count_o(tc), .armed_o(armed), .irq_o(irq));
    cms_src_gate i_cms_src_gate (.clk_i(clk_i), .source_o(source), .gate_o(gate));
    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            fails++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic end_of_test();
        if (exp_q.size() != 0) fails++;
        $display("checks %0d fails %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    // read answers: the oldest note is compared whenever a read is acknowledged
    always @(posedge clk_i)
        if (ack_o === 1'b1 && we === 1'b0)
        begin
            if (exp_q.size() == 0)
                check("unexpected ack", 32'h1, 32'h0);
            else
            begin
                e_front = exp_q.pop_front();
                check(e_front.nm, dat_o, e_front.v);
            end
        end
    // one classic cycle, held until ack is sampled high at a rising edge, released right after it
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        dat <= d;
        sel <= {3'($random(seed)), 1'b1}; // upper lanes random: only the command write looks at sel_i, and only bit 0
        do
        begin
            @(posedge clk_i);
            n++;
        end while (ack_o !== 1'b1 && n < 50);
        if (ack_o !== 1'b1)
        begin
            check("ack timeout", 32'h1, 32'h0);
            end_of_test();
        end
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
        @(posedge clk_i);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        wb(1'b1, a, d);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] v, input string nm);
        exp_q.push_back('{nm, v});
        wb(1'b0, a, 32'h0);
    endtask
    // irq, terminal count and armed ports, sampled mid-cycle
    task automatic sp(input logic [2:0] v);
        @(negedge clk_i);
        check("irq tc armed", {29'h0, irq, tc, armed}, {29'h0, v});
        @(posedge clk_i);
    endtask
    // main sequence
    initial
    begin
        logic [31:0] l;
        int hi;
        clk_i = 1'b0;
        rst_i = 1'b1;
        cyc = 1'b0;
        stb = 1'b0;
        we = 1'b0;
        adr = 8'h00;
        sel = 4'h0;
        dat = 32'h00000000;
        l = 32'(2 + $unsigned($random(seed)) % 4);
        hi = 1 + $unsigned($random(seed)) % 3;
        repeat (10) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        for (int i = 0; i < 9; i++) rd(8'(i * 4), 32'h0, "reset value");
        wr(8'h20, 32'hffff_ffff);
        rd(8'h20, 32'h0, "unmapped");
        wr(CMS_OFF_MODE, 32'hffff_0000);
        rd(CMS_OFF_MODE, 32'h0, "mode upper");
        // mode A: load, no count until armed, gate ignored, reload and disarm at tc
        wr(CMS_OFF_LOAD, l);
        wr(CMS_OFF_CMD, 32'h4);
        i_cms_src_gate.pulse(2, 1);
        rd(CMS_OFF_COUNT, l, "count unarmed");
        wr(CMS_OFF_CMD, 32'h1);
        sp(3'b001);
        i_cms_src_gate.set_gate(1'b1);
        i_cms_src_gate.pulse(1, hi);
        rd(CMS_OFF_COUNT, l - 1, "count one edge");
        i_cms_src_gate.set_gate(1'b0);
        rd(CMS_OFF_COUNT, l - 1, "no gate retrigger");
        i_cms_src_gate.pulse(int'(l) - 1, 1);
        rd(CMS_OFF_STAT, 32'h3, "stat at tc");
        i_cms_src_gate.pulse(1, 1);
        rd(CMS_OFF_COUNT, l, "reload load");
        sp(3'b000);
        i_cms_src_gate.pulse(2, 1);
        rd(CMS_OFF_COUNT, l, "count disarmed");
        // interrupts: mask, raise, clear by writing one
        rd(CMS_OFF_IRQ_STAT, 32'h3, "irq status");
        wr(CMS_OFF_IRQ_MASK, 32'h1);
        sp(3'b100);
        wr(CMS_OFF_IRQ_STAT, 32'h1);
        rd(CMS_OFF_IRQ_STAT, 32'h2, "irq w1c");
        sp(3'b000);
        wr(CMS_OFF_IRQ_MASK, 32'h2);
        sp(3'b100);
        wr(CMS_OFF_IRQ_STAT, 32'h7);
        sp(3'b000);
        // mode D: repetition keeps it armed; disarm in tc still lets the next edge count
        wr(CMS_OFF_MODE, 32'h0020);
        wr(CMS_OFF_LOAD, 32'h2);
        wr(CMS_OFF_CMD, 32'h5);
        i_cms_src_gate.pulse(3, 1);
        rd(CMS_OFF_COUNT, 32'h2, "rep reload");
        rd(CMS_OFF_STAT, 32'h1, "rep armed");
        i_cms_src_gate.pulse(2, 1);
        wr(CMS_OFF_CMD, 32'h2);
        i_cms_src_gate.pulse(1, 1);
        rd(CMS_OFF_COUNT, 32'h2, "tc counts");
        rd(CMS_OFF_STAT, 32'h0, "disarmed after tc");
        // mode N: gate edge captures into hold and reloads from load
        wr(CMS_OFF_IRQ_STAT, 32'h7);
        wr(CMS_OFF_MODE, 32'h2080);
        rd(CMS_OFF_MODE, 32'h2080, "mode n");
        wr(CMS_OFF_LOAD, 32'h9);
        wr(CMS_OFF_CMD, 32'h5);
        i_cms_src_gate.set_gate(1'b1);
        i_cms_src_gate.pulse(3, 1);
        i_cms_src_gate.set_gate(1'b0);
        i_cms_src_gate.set_gate(1'b1);
        rd(CMS_OFF_HOLD, 32'h6, "hold capture");
        rd(CMS_OFF_COUNT, 32'h9, "retrigger reload");
        rd(CMS_OFF_IRQ_STAT, 32'h4, "gate event");
        // mode X: gate edge captures, counting goes on
        i_cms_src_gate.set_gate(1'b0);
        wr(CMS_OFF_MODE, 32'hc0e0);
        wr(CMS_OFF_CMD, 32'h5);
        i_cms_src_gate.set_gate(1'b1);
        i_cms_src_gate.pulse(2, 1);
        i_cms_src_gate.set_gate(1'b0);
        i_cms_src_gate.set_gate(1'b1);
        i_cms_src_gate.pulse(1, 1);
        rd(CMS_OFF_HOLD, 32'h7, "capture no reload");
        rd(CMS_OFF_COUNT, 32'h6, "count continues");
        // mode S: reload from hold with gate high, from load with gate low
        i_cms_src_gate.set_gate(1'b0);
        wr(CMS_OFF_MODE, 32'h00c0);
        wr(CMS_OFF_LOAD, 32'h2);
        wr(CMS_OFF_HOLD, 32'h5);
        wr(CMS_OFF_CMD, 32'h5);
        i_cms_src_gate.pulse(2, 1);
        i_cms_src_gate.set_gate(1'b1);
        i_cms_src_gate.pulse(1, 1);
        rd(CMS_OFF_COUNT, 32'h5, "reload hold");
        wr(CMS_OFF_CMD, 32'h1);
        i_cms_src_gate.set_gate(1'b0);
        i_cms_src_gate.pulse(6, 1);
        rd(CMS_OFF_COUNT, 32'h2, "reload load gate low");
        end_of_test();
    end
endmodule

// ### sim/cms_src_gate.sv
/*
 * Far-side model: drives the count source and the gate of one counter.
 * Assumes the bench calls its tasks just after a rising edge of clk_i.
 */
`timescale 1ns/10ps
module cms_src_gate
(
    input wire logic clk_i,
    output logic source_o,
    output logic gate_o
);
    // both lines idle low from time zero
    initial
    begin
        source_o = 1'b0;
        gate_o = 1'b0;
    end
    // n source pulses, each high for hi cycles then low two cycles so every edge is seen
    task automatic pulse(input int n, input int hi);
        repeat (n)
        begin
            source_o <= 1'b1;
            repeat (hi) @(posedge clk_i);
            source_o <= 1'b0;
            repeat (2) @(posedge clk_i);
        end
        repeat (2) @(posedge clk_i); // let the count land
    endtask
    // gate level change, with time for any capture or reload to land
    task automatic set_gate(input logic v);
        gate_o <= v;
        repeat (3) @(posedge clk_i);
    endtask
endmodule
